// ### design/chsf_status_flags.sv
// status flag register bank of the card host controller with AXI4-Lite slave
//
// Functional notes
// - underrun set; clear by command or read
// - overrun set; clear by command or read
// - transfer done when command ready, bus idle
// - fifo empty flag follows fifo contents
// - dma done set, cleared by status read
// - dma block overrun set, read clears
// - completion timeout set, read clears
// - data timeout set, read clears
// - data crc error set, read clears
// - response timeout cleared by command write
// - response end bit error, command write clears
// - response crc error, command write clears
// - response direction error, command write clears
// - response index error, command write clears
// - dma buffer levels shown live
// - completion signal received, read clears
// - read wait state shown live
// - slot a/b card irq, read clears
// - not busy cleared at response, set later
// - data in progress until crc done
// - block ended on write, read clears
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "chsf_defines.svh"

module chsf_status_flags #(
  parameter int ADDR_W = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // event strobes from the engines, same clock
  input wire chsf_pkg::chsf_events_t i_evt,
  // live conditions from the engines, same clock
  input wire chsf_pkg::chsf_levels_t i_lvl,
  input wire logic i_new_data_cmd,
  input wire logic i_cmd_reg_write,
  input wire logic i_rsp_end,
  input wire logic i_busy_end,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_flow_err_clear_mode
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
    $error("address width must hold the register offsets");
  end

  // ----------------------------------------
  // register map constants
  // ----------------------------------------
  localparam logic [31:0] STATUS_ADDR = 32'(`CHSF_STATUS_OFFS);
  localparam logic [31:0] CTRL_ADDR = 32'(`CHSF_CTRL_OFFS);
  localparam logic [31:0] CTRL_RST = `CHSF_CTRL_RST;
  localparam logic [31:0] EVT_MASK = `CHSF_EVT_MASK;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0] sticky_q;
  logic [31:0] sticky_d;
  logic [31:0] set_vec;
  logic [31:0] live_vec;
  logic [31:0] clr_vec;
  logic [31:0] status_word;
  logic not_busy_q;
  logic ferr_mode_q;
  chsf_pkg::chsf_rd_state_t rd_st_q;
  chsf_pkg::chsf_wr_state_t wr_st_q;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic status_read;
  logic [31:0] read_snap;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic ar_take;
  logic ar_status_hit;
  logic ar_ctrl_hit;
  logic aw_ctrl_hit;
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  // ----------------------------------------
  // event and live vectors
  // ----------------------------------------
  always_comb begin
    set_vec = 32'h00000000;
    set_vec[`CHSF_BIT_UNDERRUN_ERROR] = i_evt.underrun;
    set_vec[`CHSF_BIT_OVERRUN_ERROR] = i_evt.overrun;
    set_vec[`CHSF_BIT_DMA_DONE_FLAG] = i_evt.dma_done;
    set_vec[`CHSF_BIT_BLKOVR] = i_evt.dma_blk_ovr;
    set_vec[`CHSF_BIT_COMPLETION_TIMEOUT_ERROR] = i_evt.cmpl_timeout;
    set_vec[`CHSF_BIT_DATA_TIMEOUT_ERROR] = i_evt.data_timeout;
    set_vec[`CHSF_BIT_DATA_CRC_ERROR] = i_evt.data_crc;
    set_vec[`CHSF_BIT_RESPONSE_TIMEOUT_ERROR] = i_evt.rsp_timeout;
    set_vec[`CHSF_BIT_RESPONSE_ENDBIT_ERROR] = i_evt.rsp_endbit;
    set_vec[`CHSF_BIT_RESPONSE_CRC_ERROR] = i_evt.rsp_crc;
    set_vec[`CHSF_BIT_RESPONSE_DIRECTION_ERROR] = i_evt.rsp_dir;
    set_vec[`CHSF_BIT_RESPONSE_INDEX_ERROR] = i_evt.rsp_index;
    set_vec[`CHSF_BIT_COMPLETION_RECEIVED] = i_evt.cmpl_rcv;
    set_vec[`CHSF_BIT_IRQB] = i_evt.irq_b;
    set_vec[`CHSF_BIT_IRQA] = i_evt.irq_a;
    set_vec[`CHSF_BIT_BLOCK_ENDED] = i_evt.blk_end;
  end

  always_comb begin
    live_vec = 32'h00000000;
    live_vec[`CHSF_BIT_TRANSFER_DONE] = i_lvl.cmd_ready & i_lvl.bus_idle;
    live_vec[`CHSF_BIT_FIFO_EMPTY_FLAG] = i_lvl.fifo_empty;
    live_vec[`CHSF_BIT_DMA_TX_EMPTY] = i_lvl.dma_tx_empty;
    live_vec[`CHSF_BIT_DMA_RX_FULL] = i_lvl.dma_rx_full;
    live_vec[`CHSF_BIT_DMA_TX_END] = i_lvl.dma_tx_end;
    live_vec[`CHSF_BIT_DMA_RX_END] = i_lvl.dma_rx_end;
    live_vec[`CHSF_BIT_RDWAIT] = i_lvl.read_wait;
    live_vec[`CHSF_BIT_CARD_NOT_BUSY] = not_busy_q;
    live_vec[`CHSF_BIT_DATA_IN_PROGRESS] = i_lvl.xfer_active;
    live_vec[`CHSF_BIT_TXRDY] = i_lvl.tx_ready;
    live_vec[`CHSF_BIT_RXRDY] = i_lvl.rx_ready;
    live_vec[`CHSF_BIT_CMDRDY] = i_lvl.cmd_ready;
  end

  assign status_word = (sticky_q & `CHSF_EVT_MASK) | live_vec;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign ar_status_hit = i_araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2];
  assign ar_ctrl_hit = i_araddr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2];
  assign aw_ctrl_hit = wr_addr[ADDR_W-1:2] == CTRL_ADDR[ADDR_W-1:2];

  // ----------------------------------------
  // clear sources
  // ----------------------------------------
  assign status_read = ar_take && ar_status_hit;
  assign read_snap = status_word;

  always_comb begin
    clr_vec = 32'h00000000;
    if (status_read) begin
      clr_vec = clr_vec | (read_snap & `CHSF_RC_MASK);
      if (ferr_mode_q) begin
        clr_vec = clr_vec | (read_snap & `CHSF_FLOW_MASK);
      end
    end
    if (i_new_data_cmd && !ferr_mode_q) begin
      clr_vec = clr_vec | `CHSF_FLOW_MASK;
    end
    if (i_cmd_reg_write) begin
      clr_vec = clr_vec | `CHSF_CMDW_MASK;
    end
  end

  // ----------------------------------------
  // sticky flag next state, one per bit
  // ----------------------------------------
  // set wins over clear
  for (genvar b = 0; b < 32; b++) begin : g_sticky
    if (EVT_MASK[b]) begin : g_flag
      assign sticky_d[b] = set_vec[b] | (sticky_q[b] & ~clr_vec[b]);
    end else begin : g_none
      assign sticky_d[b] = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sticky_q <= `CHSF_STATUS_RST & `CHSF_EVT_MASK;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // ----------------------------------------
  // card not busy tracking
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      not_busy_q <= 1'b1;
    end else if (i_busy_end) begin
      not_busy_q <= 1'b1;
    end else if (i_rsp_end) begin
      not_busy_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign wr_go = (aw_held_q || aw_take) && (w_held_q || w_take) && (wr_st_q == chsf_pkg::CHSF_WR_IDLE);
  assign wr_addr = aw_held_q ? aw_addr_q : i_awaddr;
  assign wr_data = w_held_q ? w_data_q : i_wdata;
  assign wr_strb = w_held_q ? w_strb_q : i_wstrb;

  // write address capture
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= i_awaddr;
    end
  end

  // write data capture
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      w_data_q <= i_wdata;
      w_strb_q <= i_wstrb;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_awready <= 1'b0;
    end else begin
      o_awready <= !aw_held_q && !aw_take && (wr_st_q == chsf_pkg::CHSF_WR_IDLE) && !wr_go;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_wready <= 1'b0;
    end else begin
      o_wready <= !w_held_q && !w_take && (wr_st_q == chsf_pkg::CHSF_WR_IDLE) && !wr_go;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_st_q <= chsf_pkg::CHSF_WR_IDLE;
      o_bvalid <= 1'b0;
    end else begin
      case (wr_st_q)
        chsf_pkg::CHSF_WR_IDLE: begin
          if (wr_go) begin
            wr_st_q <= chsf_pkg::CHSF_WR_RESP;
            o_bvalid <= 1'b1;
          end
        end
        chsf_pkg::CHSF_WR_RESP: begin
          if (i_bready) begin
            wr_st_q <= chsf_pkg::CHSF_WR_IDLE;
            o_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_st_q <= chsf_pkg::CHSF_WR_IDLE;
          o_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // write response code, latched as the write goes
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_bresp <= `CHSF_RESP_OKAY;
    end else if (wr_go) begin
      o_bresp <= aw_ctrl_hit ? `CHSF_RESP_OKAY : `CHSF_RESP_SLVERR;
    end
  end

  // control word: flow error clear mode
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ferr_mode_q <= CTRL_RST[`CHSF_CTRL_FERR_BIT];
    end else if (wr_go && aw_ctrl_hit && wr_strb[0]) begin
      ferr_mode_q <= wr_data[`CHSF_CTRL_FERR_BIT];
    end
  end

  // registered copy for the engines
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_flow_err_clear_mode <= 1'b0;
    end else begin
      o_flow_err_clear_mode <= ferr_mode_q;
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  assign ar_take = i_arvalid && o_arready;

  // read data select
  always_comb begin
    rd_word = 32'h00000000;
    rd_resp = `CHSF_RESP_OKAY;
    if (ar_status_hit) begin
      rd_word = read_snap;
    end else if (ar_ctrl_hit) begin
      rd_word = {31'h00000000, ferr_mode_q};
    end else begin
      rd_resp = `CHSF_RESP_SLVERR;
    end
  end

  // read data and response, latched as the address is taken
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h00000000;
      o_rresp <= `CHSF_RESP_OKAY;
    end else if (ar_take) begin
      o_rdata <= rd_word;
      o_rresp <= rd_resp;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_st_q <= chsf_pkg::CHSF_RD_IDLE;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
    end else begin
      case (rd_st_q)
        chsf_pkg::CHSF_RD_IDLE: begin
          o_arready <= !ar_take;
          if (ar_take) begin
            rd_st_q <= chsf_pkg::CHSF_RD_RESP;
            o_rvalid <= 1'b1;
          end
        end
        chsf_pkg::CHSF_RD_RESP: begin
          o_arready <= 1'b0;
          if (i_rready) begin
            rd_st_q <= chsf_pkg::CHSF_RD_IDLE;
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
          end
        end
        default: begin
          rd_st_q <= chsf_pkg::CHSF_RD_IDLE;
          o_rvalid <= 1'b0;
          o_arready <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ### design/chsf_defines.svh
// offsets, field positions, reset values and masks of the status flag block
`ifndef CHSF_DEFINES_SVH
`define CHSF_DEFINES_SVH
`define CHSF_STATUS_OFFS 12'h040
`define CHSF_CTRL_OFFS 12'h058
`define CHSF_STATUS_RST 32'h0c000025
`define CHSF_CTRL_RST 32'h00000000
`define CHSF_BIT_UNDERRUN_ERROR 31
`define CHSF_BIT_OVERRUN_ERROR 30
`define CHSF_BIT_TRANSFER_DONE 27
`define CHSF_BIT_FIFO_EMPTY_FLAG 26
`define CHSF_BIT_DMA_DONE_FLAG 25
`define CHSF_BIT_BLKOVR 24
`define CHSF_BIT_COMPLETION_TIMEOUT_ERROR 23
`define CHSF_BIT_DATA_TIMEOUT_ERROR 22
`define CHSF_BIT_DATA_CRC_ERROR 21
`define CHSF_BIT_RESPONSE_TIMEOUT_ERROR 20
`define CHSF_BIT_RESPONSE_ENDBIT_ERROR 19
`define CHSF_BIT_RESPONSE_CRC_ERROR 18
`define CHSF_BIT_RESPONSE_DIRECTION_ERROR 17
`define CHSF_BIT_RESPONSE_INDEX_ERROR 16
`define CHSF_BIT_DMA_TX_EMPTY 15
`define CHSF_BIT_DMA_RX_FULL 14
`define CHSF_BIT_COMPLETION_RECEIVED 13
`define CHSF_BIT_RDWAIT 12
`define CHSF_BIT_IRQB 9
`define CHSF_BIT_IRQA 8
`define CHSF_BIT_DMA_TX_END 7
`define CHSF_BIT_DMA_RX_END 6
`define CHSF_BIT_CARD_NOT_BUSY 5
`define CHSF_BIT_DATA_IN_PROGRESS 4
`define CHSF_BIT_BLOCK_ENDED 3
`define CHSF_BIT_TXRDY 2
`define CHSF_BIT_RXRDY 1
`define CHSF_BIT_CMDRDY 0
`define CHSF_CTRL_FERR_BIT 0
// read-to-clear set (dma done, blkovr, completion_timeout_error, data_timeout_error, data_crc_error, completion_received, irqb, irqa, block_ended)
`define CHSF_RC_MASK 32'h03e02308
// cleared by command register write
`define CHSF_CMDW_MASK 32'h001f0000
// flow errors
`define CHSF_FLOW_MASK 32'hc0000000
// sticky event bits as a whole
`define CHSF_EVT_MASK 32'hc3ff2308
`define CHSF_RESP_OKAY 2'b00
`define CHSF_RESP_SLVERR 2'b10
`endif

// ### design/chsf_pkg.sv
// types of the status flag block
package chsf_pkg;
  typedef struct packed {
    logic underrun;
    logic overrun;
    logic dma_done;
    logic dma_blk_ovr;
    logic cmpl_timeout;
    logic data_timeout;
    logic data_crc;
    logic rsp_timeout;
    logic rsp_endbit;
    logic rsp_crc;
    logic rsp_dir;
    logic rsp_index;
    logic cmpl_rcv;
    logic irq_b;
    logic irq_a;
    logic blk_end;
  } chsf_events_t;

  typedef struct packed {
    logic cmd_ready;
    logic bus_idle;
    logic fifo_empty;
    logic dma_tx_empty;
    logic dma_rx_full;
    logic dma_tx_end;
    logic dma_rx_end;
    logic read_wait;
    logic xfer_active;
    logic tx_ready;
    logic rx_ready;
  } chsf_levels_t;

  typedef enum logic [1:0] {
    CHSF_RD_IDLE,
    CHSF_RD_RESP
  } chsf_rd_state_t;

  typedef enum logic [1:0] {
    CHSF_WR_IDLE,
    CHSF_WR_RESP
  } chsf_wr_state_t;
endpackage

// ### test/chsf_tb_pkg.sv
// expected status word helpers for the bench side
`include "chsf_defines.svh"
package chsf_tb_pkg;
  function automatic logic [31:0] ev_bits(chsf_pkg::chsf_events_t e);
    return {e[15:14], 4'h0, e[13:4], 2'h0, e[3], 3'h0, e[2:1], 4'h0, e[0], 3'h0};
  endfunction
  function automatic logic [31:0] clr_bits(logic rd, logic cw, logic nd, logic m);
    return (rd ? (`CHSF_RC_MASK | (m ? `CHSF_FLOW_MASK : 32'h0)) : 32'h0)
      | (cw ? `CHSF_CMDW_MASK : 32'h0) | ((nd && !m) ? `CHSF_FLOW_MASK : 32'h0);
  endfunction
  function automatic logic [31:0] word(logic [31:0] s, chsf_pkg::chsf_levels_t l, logic nb);
    return s | {4'h0, l.cmd_ready & l.bus_idle, l.fifo_empty, 10'h0, l.dma_tx_empty,
      l.dma_rx_full, 1'b0, l.read_wait, 4'h0, l.dma_tx_end, l.dma_rx_end, nb, l.xfer_active,
      1'b0, l.tx_ready, l.rx_ready, l.cmd_ready};
  endfunction
endpackage

// ### test/chsf_status_monitor.sv
// assertion checker of the status flag block
`timescale 1ns/1ps
`include "chsf_defines.svh"
module chsf_status_monitor #(
  parameter int ADDR_W = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire chsf_pkg::chsf_events_t i_evt,
  input wire chsf_pkg::chsf_levels_t i_lvl,
  input wire logic i_new_data_cmd,
  input wire logic i_cmd_reg_write,
  input wire logic i_rsp_end,
  input wire logic i_busy_end,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid
);
  // ----------------------------------------
  // reference flags and checks
  // ----------------------------------------
  logic [31:0] stk_q;
  logic nb_q;
  logic mode_q;
  logic rd_take;
  logic rd_bad;
  logic [31:0] exp_w;
  assign rd_take = i_arvalid && o_arready && i_araddr == ADDR_W'('h40);
  assign rd_bad = i_arvalid && o_arready && i_araddr == ADDR_W'('h7c);
  assign exp_w = chsf_tb_pkg::word(stk_q, i_lvl, nb_q);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stk_q <= 32'h0;
    end else begin
      stk_q <= (stk_q & ~chsf_tb_pkg::clr_bits(rd_take, i_cmd_reg_write, i_new_data_cmd, mode_q))
        | chsf_tb_pkg::ev_bits(i_evt);
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nb_q <= 1'b1;
    end else begin
      nb_q <= i_busy_end | (nb_q & ~i_rsp_end);
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q <= 1'b0;
    end else if (i_wvalid && o_wready && i_awaddr == ADDR_W'('h58)) begin
      mode_q <= i_wdata[0];
    end
  end
  property shows_p(logic [31:0] m);
    rd_take |=> o_rvalid && (o_rdata & m) == ($past(exp_w) & m);
  endproperty
  flow_err_a:
    assert property (shows_p(32'hc0000000)) else $error("flow error bits wrong");
  dma_evt_a:
    assert property (shows_p(32'h03e00000)) else $error("dma and data error bits wrong");
  rsp_err_a:
    assert property (shows_p(32'h001f0000)) else $error("response error bits wrong");
  card_evt_a:
    assert property (shows_p(32'h00002308)) else $error("card event bits wrong");
  not_busy_a:
    assert property (shows_p(32'h00000020)) else $error("not busy bit wrong");
  xfer_done_a:
    assert property (rd_take |=> o_rdata[27] == $past(i_lvl.cmd_ready && i_lvl.bus_idle))
    else $error("transfer done bit wrong");
  live_lvl_a:
    assert property (shows_p(32'h0400d0d0)) else $error("live level bits wrong");
  bad_read_a:
    assert property (rd_bad |=> o_rvalid && o_rresp == 2'b10 && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  cover property (rd_take && (chsf_tb_pkg::ev_bits(i_evt) & `CHSF_RC_MASK) != 32'h0);
  cover property (rd_take && mode_q && (stk_q[31] || stk_q[30]));
  cover property (rd_bad);
endmodule
bind chsf_status_flags chsf_status_monitor #(.ADDR_W(ADDR_W)) u_mon (.i_sys_clk, .i_rstn,
  .i_evt, .i_lvl, .i_new_data_cmd, .i_cmd_reg_write, .i_rsp_end, .i_busy_end, .i_awaddr,
  .i_wdata, .i_wvalid, .o_wready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
  .o_rvalid);

// ### test/chsf_card_model.sv
// card side model: response end and data0 busy release
`timescale 1ns/1ps
module chsf_card_model (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_cmd,
  output logic o_rsp_end,
  output logic o_busy_end
);
  logic [3:0] busy_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_q <= 4'h0;
      o_rsp_end <= 1'b0;
      o_busy_end <= 1'b0;
    end else begin
      o_rsp_end <= i_cmd;
      o_busy_end <= (busy_q == 4'h1);
      busy_q <= i_cmd ? 4'($urandom_range(9, 2)) : busy_q - 4'(busy_q != 4'h0);
    end
  end
endmodule

// ### test/chsf_status_flags_tb.sv
// self-checking bench of the status flag block
`timescale 1ns/1ps
`include "chsf_defines.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module chsf_status_flags_tb;
  logic clk = 1'b0, rstn = 1'b0, ndc = 1'b0, cw = 1'b0, run = 1'b0, mode = 1'b0, nb = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  chsf_pkg::chsf_events_t evt = '0;
  chsf_pkg::chsf_levels_t lvl = 11'h702;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, stk = 32'h0, snap, d;
  logic [3:0] wstrb = 4'h1;
  logic [1:0] r, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, fmode, rsp_end, busy_end;
  logic [31:0] rdata;
  int errors = 0, checked = 0, cyc = 0, rnd;
  chsf_status_flags uut (.i_sys_clk(clk), .i_rstn(rstn), .i_evt(evt), .i_lvl(lvl),
    .i_new_data_cmd(ndc), .i_cmd_reg_write(cw), .i_rsp_end(rsp_end), .i_busy_end(busy_end),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(rstn), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rstn),
    .o_flow_err_clear_mode(fmode));
  chsf_card_model card (.i_sys_clk(clk), .i_rstn(rstn), .i_cmd(cw), .o_rsp_end(rsp_end),
    .o_busy_end(busy_end));
  // ----------------------------------------
  // clock, stimulus and reference
  // ----------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    evt <= run ? 16'($urandom & $urandom & $urandom) : 16'h0;
    lvl <= run ? 11'($urandom) : lvl;
    ndc <= run && ($urandom_range(7) == 0);
    cw <= run && ($urandom_range(7) == 0);
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stk <= 32'h0;
      nb <= 1'b1;
      mode <= 1'b0;
    end else begin
      stk <= (stk & ~chsf_tb_pkg::clr_bits(arvalid && arready && araddr == 12'h040, cw, ndc,
        mode)) | chsf_tb_pkg::ev_bits(evt);
      nb <= busy_end | (nb & ~rsp_end);
      if (arvalid && arready) snap <= chsf_tb_pkg::word(stk, lvl, nb);
      if (wvalid && wready && awaddr == 12'h058) mode <= wdata[0];
    end
  end
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rnd = $urandom(70463);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(12'h040);
    `CHK("reset word", `CHSF_STATUS_RST, d)
    for (int m = 0; m < 2; m++) begin
      wr(12'h058, 32'(m));
      @(posedge clk);
      `CHK("mode", 1'(m), fmode)
      rd(12'h058);
      `CHK("ctrl read", {`CHSF_RESP_OKAY, 32'(m)}, {r, d})
      run <= 1'b1;
      repeat (150) begin
        rd(12'h040);
        `CHK("flow", snap & 32'hc0000000, d & 32'hc0000000)
        `CHK("dma", snap & 32'h03000000, d & 32'h03000000)
        `CHK("data err", snap & 32'h00e00000, d & 32'h00e00000)
        `CHK("rsp tmo", snap & 32'h00100000, d & 32'h00100000)
        `CHK("rsp", snap & 32'h000f0000, d & 32'h000f0000)
        `CHK("card", snap & 32'h00002308, d & 32'h00002308)
        `CHK("done", snap & 32'h0c000000, d & 32'h0c000000)
        `CHK("live", snap & 32'h0000d0f7, d & 32'h0000d0f7)
        `CHK("not busy", snap[5], d[5])
        repeat ($urandom_range(3)) @(posedge clk);
      end
      run <= 1'b0;
    end
    wr(12'h040, 32'hffffffff);
    `CHK("ro write", `CHSF_RESP_SLVERR, r)
    rd(12'h07c);
    `CHK("bad read", {`CHSF_RESP_SLVERR, 32'h0}, {r, d})
    stop_test();
  end
endmodule
